// ===== src/dulc_align.sv
// data word alignment of a high/low byte pair into a 12-bit code
`timescale 1ns/1ps
module dulc_align
   import dulc_pkg::*;
(
   input  wire logic [7:0]  high_byte,
   input  wire logic [7:0]  low_byte,
   input  wire logic [2:0]  data_format,
   output logic      [11:0] code
);

   logic [15:0] pair;
   logic [15:0] shifted;

   // ----------------------------------------------------------------------------
   // upper bits right-justified in the high byte, the rest left-justified low
   // ----------------------------------------------------------------------------
   always_comb
   begin
      pair = {high_byte, low_byte};
      if (data_format[2])
      begin
         shifted = pair >> 4; // R13
      end
      else
      begin
         shifted = pair >> data_format[1:0]; // R11
      end
      code = shifted[11:0];
   end

endmodule

// ===== src/dulc_defs.svh
// register offsets, field positions, reset values for the converter update control
`ifndef DULC_DEFS_SVH
`define DULC_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets on the special function register bus
// ----------------------------------------------------------------------------
`define DULC_OFS_LOW0     8'hd2
`define DULC_OFS_HIGH0    8'hd3
`define DULC_OFS_CTRL0    8'hd4
`define DULC_CH_STRIDE    8'h03

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define DULC_EN_BIT       7
`define DULC_MD_HI        4
`define DULC_MD_LO        3
`define DULC_DF_HI        2
`define DULC_DF_LO        0
`define DULC_CTRL_MASK    8'h9f

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DULC_CTRL_RST     8'h00
`define DULC_BYTE_RST     8'h00
`define DULC_CODE_RST     12'h000

`endif

// ===== src/dulc_pkg.sv
// types shared by the converter update control
package dulc_pkg;

   // update source selected by the mode field
   typedef enum logic [1:0]
   {
      DULC_MODE_ON_DEMAND = 2'h0,
      DULC_MODE_TIMER3    = 2'h1,
      DULC_MODE_TIMER4    = 2'h2,
      DULC_MODE_TIMER2    = 2'h3
   } dulc_mode_t;

   // state of one converter
   typedef struct packed
   {
      logic [7:0]  ctrl;
      logic [7:0]  low_held;
      logic [7:0]  high_held;
      logic [7:0]  high_latch;
      logic [11:0] code;
      logic        update;
   } dulc_chan_t;

endpackage

// ===== src/dulc_top.sv
// two 12-bit converter data holding, update scheduling and read-back logic
//
// Contract
// R1 - each converter takes codes 0x000 to 0xfff, zero is zero output.
// R2 - enable cleared puts output pin high-impedance and converter in shutdown.
// R3 - low byte read returns the last value written to it.
// R4 - high byte read returns the value in the high-byte input latch.
// R5 - mode 00 transfers held data to the latch on each high byte write.
// R6 - on-demand mode holds low byte writes until the next high byte write.
// R7 - software writes low byte first, high byte second for full resolution.
// R8 - for 8-bit use, low byte set once, then only high byte written.
// R9 - modes 01, 10, 11 hold writes until timer 3, 4 or 2 overflow.
// R10 - on the selected overflow both held bytes are latched together.
// R11 - format field bits 2:0 picks one of five word alignments.
// R12 - second converter behaves the same with its own registers.
// R13 - formats 000 to 011 put 4 to 7 upper bits high, 1xx eight.
// R14 - control bit 7 enables the output pin and leaves shutdown.
// R15 - after reset held data and latches are zero.
`timescale 1ns/1ps
`include "dulc_defs.svh"
module dulc_top
   import dulc_pkg::*;
#(
   parameter int NUM_CH = 2
)
(
   input  wire logic                   core_clk,
   input  wire logic                   reset_n,
   input  wire logic [7:0]             sfr_addr,
   input  wire logic                   sfr_wr_en,
   input  wire logic [7:0]             sfr_wdata,
   input  wire logic                   tmr2_ovf,
   input  wire logic                   tmr3_ovf,
   input  wire logic                   tmr4_ovf,
   output logic      [7:0]             sfr_rdata,
   output logic                        sfr_hit,
   output logic      [NUM_CH*12-1:0]   conv_code,
   output logic      [NUM_CH-1:0]      conv_out_en,
   output logic      [NUM_CH-1:0]      conv_shutdown,
   output logic      [NUM_CH-1:0]      conv_update
);

   typedef struct packed
   {
      dulc_chan_t [NUM_CH-1:0] chan;
   } dulc_state_t;

   dulc_state_t             st;
   dulc_state_t             next_st;

   logic [NUM_CH-1:0]       wr_low;
   logic [NUM_CH-1:0]       wr_high;
   logic [NUM_CH-1:0]       wr_ctrl;
   logic [NUM_CH-1:0]       xfer;
   logic [NUM_CH-1:0][7:0]  merged_low;
   logic [NUM_CH-1:0][7:0]  merged_high;
   logic [NUM_CH-1:0][11:0] aligned;
   logic [NUM_CH-1:0][7:0]  base_addr;

   // ----------------------------------------------------------------------------
   // per-converter decode, update source and alignment
   // ----------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_chan
         dulc_mode_t mode;

         // converters sit in consecutive groups of three registers
         assign base_addr[gi] = `DULC_OFS_LOW0 + 8'(gi) * `DULC_CH_STRIDE; // R12
         assign wr_low[gi]    = sfr_wr_en && (sfr_addr == base_addr[gi]);
         assign wr_high[gi]   = sfr_wr_en && (sfr_addr == base_addr[gi] + 8'h01);
         assign wr_ctrl[gi]   = sfr_wr_en && (sfr_addr == base_addr[gi] + 8'h02);
         assign mode          = dulc_mode_t'(st.chan[gi].ctrl[`DULC_MD_HI:`DULC_MD_LO]);

         // a write landing with the overflow is taken into the same transfer
         assign merged_low[gi]  = wr_low[gi] ? sfr_wdata : st.chan[gi].low_held;
         assign merged_high[gi] = wr_high[gi] ? sfr_wdata : st.chan[gi].high_held;

         always_comb
         begin
            case (mode)
               DULC_MODE_ON_DEMAND: xfer[gi] = wr_high[gi]; // R5 R6
               DULC_MODE_TIMER3:    xfer[gi] = tmr3_ovf;    // R9
               DULC_MODE_TIMER4:    xfer[gi] = tmr4_ovf;    // R9
               DULC_MODE_TIMER2:    xfer[gi] = tmr2_ovf;    // R9
               default:             xfer[gi] = 1'b0;
            endcase
         end

         dulc_align u_align
         (
            .high_byte   (merged_high[gi]),
            .low_byte    (merged_low[gi]),
            .data_format (st.chan[gi].ctrl[`DULC_DF_HI:`DULC_DF_LO]),
            .code        (aligned[gi])
         );

         assign conv_code[gi*12 +: 12] = st.chan[gi].code;                    // R1
         assign conv_out_en[gi]        = st.chan[gi].ctrl[`DULC_EN_BIT];      // R14
         assign conv_shutdown[gi]      = !st.chan[gi].ctrl[`DULC_EN_BIT];     // R2
         assign conv_update[gi]        = st.chan[gi].update;
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      for (int i = 0; i < NUM_CH; i++)
      begin
         next_st.chan[i].update = 1'b0;
         if (wr_ctrl[i])
         begin
            // unused bits 6:5 are dropped so they read back as zero
            next_st.chan[i].ctrl = sfr_wdata & `DULC_CTRL_MASK; // R14
         end
         next_st.chan[i].low_held  = merged_low[i];  // R3
         next_st.chan[i].high_held = merged_high[i]; // R6
         if (xfer[i])
         begin
            // both bytes move together so the output never shows a half word
            next_st.chan[i].high_latch = merged_high[i]; // R10
            next_st.chan[i].code       = aligned[i];     // R10 R11
            next_st.chan[i].update     = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            st.chan[i].ctrl       <= `DULC_CTRL_RST;
            st.chan[i].low_held   <= `DULC_BYTE_RST;  // R15
            st.chan[i].high_held  <= `DULC_BYTE_RST;  // R15
            st.chan[i].high_latch <= `DULC_BYTE_RST;  // R15
            st.chan[i].code       <= `DULC_CODE_RST;  // R15
            st.chan[i].update     <= 1'b0;
         end
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------------
   // read-back; combinational mux of registered values, zero when unmapped
   // ----------------------------------------------------------------------------
   always_comb
   begin
      sfr_rdata = 8'h00;
      sfr_hit   = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (sfr_addr == base_addr[i])
         begin
            sfr_rdata = st.chan[i].low_held; // R3
            sfr_hit   = 1'b1;
         end
         else if (sfr_addr == base_addr[i] + 8'h01)
         begin
            // the held high byte is not visible until it is latched
            sfr_rdata = st.chan[i].high_latch; // R4
            sfr_hit   = 1'b1;
         end
         else if (sfr_addr == base_addr[i] + 8'h02)
         begin
            sfr_rdata = st.chan[i].ctrl;
            sfr_hit   = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // checks per converter
   // ----------------------------------------------------------------------------
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_chk
         low_readback_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
            wr_low[gi] ##1 (sfr_addr == base_addr[gi] && !sfr_wr_en)
            |-> sfr_rdata == $past(sfr_wdata))
            else $error("low byte read-back differs from last write");

         high_readback_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
            (wr_high[gi] && !xfer[gi]) ##1 (sfr_addr == base_addr[gi] + 8'h01)
            |-> sfr_rdata == $past(st.chan[gi].high_latch))
            else $error("held high byte visible before latching");

         ondemand_update_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
            (wr_high[gi] && st.chan[gi].ctrl[4:3] == 2'b00 && st.chan[gi].ctrl[2])
            |=> conv_update[gi] && st.chan[gi].code[11:4] == $past(sfr_wdata))
            else $error("high byte write did not update output");

         low_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
            (st.chan[gi].ctrl[4:3] == 2'b00 && !wr_high[gi])
            |=> $stable(st.chan[gi].code) && !conv_update[gi])
            else $error("output changed without high byte write");

         timer_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R9
            (st.chan[gi].ctrl[4:3] != 2'b00 && !xfer[gi])
            |=> $stable(st.chan[gi].code))
            else $error("output changed without timer overflow");

         timer_copy_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
            (st.chan[gi].ctrl[4:3] == 2'b01 && tmr3_ovf)
            |=> conv_update[gi] && st.chan[gi].high_latch == $past(merged_high[gi])
                && st.chan[gi].code == $past(aligned[gi]))
            else $error("timer 3 overflow did not latch held data");

         timer_select_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R9
            (st.chan[gi].ctrl[4:3] == 2'b10 && !tmr4_ovf) |=> !conv_update[gi])
            else $error("update without timer 4 overflow");

         format_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
            (xfer[gi] && st.chan[gi].ctrl[2:0] == 3'b000)
            |=> st.chan[gi].code == {$past(merged_high[gi][3:0]), $past(merged_low[gi])})
            else $error("format 000 alignment wrong");

         format_eight_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
            (xfer[gi] && st.chan[gi].ctrl[2])
            |=> st.chan[gi].code == {$past(merged_high[gi]), $past(merged_low[gi][7:4])})
            else $error("format 1xx alignment wrong");

         enable_off_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
            (wr_ctrl[gi] && !sfr_wdata[7])
            |=> !conv_out_en[gi] && conv_shutdown[gi])
            else $error("disabled converter still drives its pin");

         reset_clear_a: assert property (@(posedge core_clk) // R15
            !reset_n |=> (!reset_n || (st.chan[gi].code == 12'h000
                && st.chan[gi].high_latch == 8'h00 && !conv_out_en[gi])))
            else $error("converter state not cleared by reset");
      end
   endgenerate

endmodule

// ===== tb/dulc_core_model.sv
// processor core model driving the register bus of the converter control
`timescale 1ns/1ps
module dulc_core_model
(
   input  wire logic       core_clk,
   input  wire logic [7:0] sfr_rdata,
   output logic      [7:0] sfr_addr,
   output logic            sfr_wr_en,
   output logic      [7:0] sfr_wdata
);
   // bus starts on an unmapped address so a stray strobe before the first access hits nothing
   initial
   begin
      sfr_addr  = 8'h00;
      sfr_wr_en = 1'b0;
      sfr_wdata = 8'h00;
   end

   // one write every two cycles, strobe held across exactly one taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
   begin
      @(posedge core_clk);
      #1;
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr_en = 1'b1;
      @(posedge core_clk);
      #1;
      sfr_wr_en = 1'b0;
      // released data must not keep looking valid
      sfr_wdata = ~d;
   end
   endtask

   // read data is combinational on the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
   begin
      @(posedge core_clk);
      #1;
      sfr_addr = a;
      #1;
      d = sfr_rdata;
   end
   endtask
endmodule

// ===== tb/test_dac_update_latch_control.sv
// self-checking bench for the two-converter update control
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module test_dac_update_latch_control;
   import dulc_pkg::*;
   logic        core_clk;
   logic        reset_n;
   logic [7:0]  sfr_addr;
   logic        sfr_wr_en;
   logic [7:0]  sfr_wdata;
   logic [3:1]  ovf;
   logic [7:0]  sfr_rdata;
   logic        sfr_hit;
   logic [23:0] conv_code;
   logic [1:0]  conv_out_en;
   logic [1:0]  conv_shutdown;
   logic [1:0]  conv_update;
   logic [7:0]  d;
   int          err_total;
   int          n_compared;

   dulc_top #(.NUM_CH(2)) uut (.core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
      .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata), .tmr2_ovf(ovf[3]), .tmr3_ovf(ovf[1]),
      .tmr4_ovf(ovf[2]), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .conv_code(conv_code),
      .conv_out_en(conv_out_en), .conv_shutdown(conv_shutdown), .conv_update(conv_update));
   dulc_core_model core (.core_clk(core_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
      .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // each of the five alignments written out as its own split of high and low bits
   function automatic logic [11:0] al(logic [7:0] h, logic [7:0] l, logic [2:0] f);
      case (f)
         3'd0:    return {h[3:0], l};
         3'd1:    return {h[4:0], l[7:1]};
         3'd2:    return {h[5:0], l[7:2]};
         3'd3:    return {h[6:0], l[7:3]};
         default: return {h, l[7:4]};
      endcase
   endfunction

   task automatic tp(input logic [3:1] v);
   begin
      @(posedge core_clk);
      #1 ovf = v;
      @(posedge core_clk);
      #1 ovf = 3'h0;
   end
   endtask

   task automatic give_verdict;
   begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
   begin
      for (int a = 'hd2; a <= 'hd7; a++)
      begin
         core.rd(8'(a), d);
         `CHK("reg", 8'h00, d)
      end
      `CHK("code", 24'h00_0000, conv_code)
      `CHK("shut", 2'h3, conv_shutdown)
      `CHK("oen", 2'h0, conv_out_en)
      $display("reset done");
   end
   endtask

   task automatic t_demand(input int ch);
      logic [7:0] b;
   begin
      b = 8'(8'hd2 + 3 * ch);
      core.wr(b, 8'hff);
      `CHK("no upd", 1'b0, conv_update[ch])
      core.wr(b + 8'h01, 8'h0f);
      `CHK("upd", 1'b1, conv_update[ch])
      `CHK("full", 12'hfff, conv_code[ch*12 +: 12])
      core.rd(b, d);
      `CHK("low rd", 8'hff, d)
      core.rd(b + 8'h01, d);
      `CHK("high rd", 8'h0f, d)
      core.wr(b, 8'h00);
      core.wr(b + 8'h01, 8'h00);
      `CHK("zero", 12'h000, conv_code[ch*12 +: 12])
      $display("on-demand done ch %0d", ch);
   end
   endtask

   task automatic t_formats;
   begin
      for (int f = 0; f < 8; f++)
      begin
         core.wr(8'hd4, 8'(f));
         core.wr(8'hd2, 8'ha5);
         core.wr(8'hd3, 8'h96);
         `CHK("fmt", al(8'h96, 8'ha5, 3'(f)), conv_code[11:0])
      end
      $display("formats done");
   end
   endtask

   task automatic t_timer(input int ch);
      logic [7:0] b;
      logic [7:0] hl;
   begin
      b  = 8'(8'hd2 + 3 * ch);
      // high latch left by earlier tests: the format sweep ends on 0x96 for ch0
      hl = (ch == 0) ? 8'h96 : 8'h00;
      for (int m = 1; m < 4; m++)
      begin
         core.wr(b + 8'h02, 8'(m * 8 + 4));
         core.wr(b, 8'h50);
         core.wr(b + 8'h01, 8'(8'hc0 + m));
         `CHK("held", 1'b0, conv_update[ch])
         core.rd(b + 8'h01, d);
         `CHK("old latch", hl, d)
         tp(~(3'h1 << (m - 1)));
         `CHK("wrong tmr", 1'b0, conv_update[ch])
         tp(3'h1 << (m - 1));
         `CHK("tmr upd", 1'b1, conv_update[ch])
         `CHK("tmr code", {4'hc, 4'(m), 4'h5}, conv_code[ch*12 +: 12])
         hl = 8'(8'hc0 + m);
      end
      // a high write landing with the overflow joins that same transfer
      fork
         core.wr(b + 8'h01, 8'h3c);
         tp(3'h4);
      join
      `CHK("merge upd", 1'b1, conv_update[ch])
      `CHK("merge code", 12'h3c5, conv_code[ch*12 +: 12])
      core.rd(b + 8'h01, d);
      `CHK("merge latch", 8'h3c, d)
      core.wr(b + 8'h02, 8'h00);
      $display("timer done ch %0d", ch);
   end
   endtask

   task automatic t_enable;
   begin
      core.wr(8'hd7, 8'he0);
      `CHK("oen", 2'h2, conv_out_en)
      `CHK("shut", 2'h1, conv_shutdown)
      core.rd(8'hd7, d);
      `CHK("ctrl rd", 8'h80, d)
      `CHK("hit ctrl", 1'b1, sfr_hit)
      core.wr(8'hd7, 8'h00);
      `CHK("shut off", 2'h3, conv_shutdown)
      core.wr(8'hd8, 8'h5a);
      core.rd(8'hd8, d);
      `CHK("unmapped", 8'h00, d)
      `CHK("hit", 1'b0, sfr_hit)
      core.wr(8'hd4, 8'h80);
      `CHK("oen0", 2'h1, conv_out_en)
      `CHK("shut0", 2'h2, conv_shutdown)
      $display("enable done");
   end
   endtask

   // ---------------------------------------------------------------
   // clock, reset, sequence, watchdog
   // ---------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial
   begin
      err_total  = 0;
      n_compared = 0;
      reset_n    = 1'b0;
      ovf        = 3'h0;
      repeat (12) @(posedge core_clk);
      #1 reset_n = 1'b1;
      t_reset();
      t_demand(0);
      t_demand(1);
      t_formats();
      t_timer(0);
      t_timer(1);
      t_enable();
      give_verdict();
   end

   // full run is under two hundred cycles; this leaves ample margin
   initial
   begin
      #50000;
      err_total++;
      give_verdict();
   end
endmodule
